// >>> src/jtp_tap_unit.sv
// One test access port controller with its instruction, bypass and ident registers.
// Assumes pin strobes from the synchroniser; test reset is folded into rst_n_i.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_unit #(
	parameter logic [31:0] ID_VALUE = jtp_pkg::JTP_ID_UNIT_DEFAULT
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire jtp_pkg::jtp_pins_s pins_i,
	output logic sdo_o,
	output var jtp_pkg::jtp_state_e state_o,
	output logic [6:0] ir_o
);
	import jtp_pkg::*;

	jtp_state_e state_reg, state_next;
	logic [6:0] ir_sh_reg, ir_sh_next, ir_reg;
	logic [31:0] id_reg, id_next;
	logic byp_reg, byp_next;
	logic tms;
	logic sel_id;
	logic dr_out;
	logic ser_out;

	assign tms = pins_i.tms;
	assign sel_id = (ir_reg == JTP_OP_IDCODE);
	assign dr_out = sel_id ? id_reg[0] : byp_reg;
	assign ser_out = (state_reg == JTP_SH_IR) ? ir_sh_reg[0] : dr_out;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			JTP_TLR: state_next = tms ? JTP_TLR : JTP_RTI;
			JTP_RTI: state_next = tms ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_DR: state_next = tms ? JTP_SEL_IR : JTP_CAP_DR;
			JTP_CAP_DR: state_next = tms ? JTP_EX1_DR : JTP_SH_DR;
			JTP_SH_DR: state_next = tms ? JTP_EX1_DR : JTP_SH_DR;
			JTP_EX1_DR: state_next = tms ? JTP_UPD_DR : JTP_PAU_DR;
			JTP_PAU_DR: state_next = tms ? JTP_EX2_DR : JTP_PAU_DR;
			JTP_EX2_DR: state_next = tms ? JTP_UPD_DR : JTP_SH_DR;
			JTP_UPD_DR: state_next = tms ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_IR: state_next = tms ? JTP_TLR : JTP_CAP_IR;
			JTP_CAP_IR: state_next = tms ? JTP_EX1_IR : JTP_SH_IR;
			JTP_SH_IR: state_next = tms ? JTP_EX1_IR : JTP_SH_IR;
			JTP_EX1_IR: state_next = tms ? JTP_UPD_IR : JTP_PAU_IR;
			JTP_PAU_IR: state_next = tms ? JTP_EX2_IR : JTP_PAU_IR;
			JTP_EX2_IR: state_next = tms ? JTP_UPD_IR : JTP_SH_IR;
			JTP_UPD_IR: state_next = tms ? JTP_SEL_DR : JTP_RTI;
			default: state_next = JTP_TLR;
		endcase
	end

	// Data register and instruction shift stage updates on rising test clock
	always_comb begin
		ir_sh_next = ir_sh_reg;
		id_next = id_reg;
		byp_next = byp_reg;
		case (state_reg)
			JTP_CAP_IR: ir_sh_next = JTP_IR_CAPTURE;
			JTP_SH_IR: ir_sh_next = {pins_i.tdi, ir_sh_reg[6:1]};
			JTP_CAP_DR: begin
				if (sel_id) id_next = ID_VALUE;
				else byp_next = 1'b0;
			end
			JTP_SH_DR: begin
				if (sel_id) id_next = {pins_i.tdi, id_reg[31:1]};
				else byp_next = pins_i.tdi;
			end
			default: ir_sh_next = ir_sh_reg; // hold when paused
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= JTP_TLR;
			ir_sh_reg <= JTP_IR_CAPTURE;
			id_reg <= 32'h0000_0000;
			byp_reg <= 1'b0;
		end else if (pins_i.rise) begin
			state_reg <= state_next;
			ir_sh_reg <= ir_sh_next;
			id_reg <= id_next;
			byp_reg <= byp_next;
		end
	end

	// Falling edge action: instruction latch
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir_reg <= JTP_OP_IDCODE;
		end else if (pins_i.fall) begin
			if (state_reg == JTP_TLR) ir_reg <= JTP_OP_IDCODE;
			else if (state_reg == JTP_UPD_IR) ir_reg <= ir_sh_reg;
		end
	end

	// Serial output is retimed once, at the top; a second retime here would add a bit of lag
	assign sdo_o = ser_out;
	assign state_o = state_reg;
	assign ir_o = ir_reg;

	// Five high samples from any state land in reset
	logic [2:0] hi_cnt;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) hi_cnt <= 3'h0;
		else if (pins_i.rise) hi_cnt <= tms ? ((hi_cnt == 3'h5) ? hi_cnt : hi_cnt + 3'h1) : 3'h0;
	end
	tlr_after_five_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(hi_cnt == 3'h5) |-> state_reg == JTP_TLR)
		else $error("controller not in reset after five high tms samples");
	ir_stable_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(state_reg != JTP_UPD_IR && state_reg != JTP_TLR) |=> $stable(ir_reg))
		else $error("instruction changed outside update or reset");
	cap_ir_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(pins_i.rise && state_reg == JTP_CAP_IR) |=> ir_sh_reg == JTP_IR_CAPTURE)
		else $error("capture pattern not loaded");
	pause_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(state_reg == JTP_PAU_DR) |=> $stable(id_reg) && $stable(byp_reg))
		else $error("data register moved while paused");
	sel_ir_exit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(pins_i.rise && state_reg == JTP_SEL_IR && tms) |=> state_reg == JTP_TLR)
		else $error("select ir with tms high did not reset");
endmodule : jtp_tap_unit
`default_nettype wire

// >>> src/jtp_pkg.sv
// Package for the test access port block: states, opcodes, widths, struct carriers.
// Assumes a single system clock that oversamples the test clock pin.
package jtp_pkg;
	localparam int JTP_IR_W = 7;
	localparam int JTP_ID_W = 32;
	localparam logic [6:0] JTP_OP_IDCODE = 7'h7e;
	localparam logic [6:0] JTP_OP_BYPASS = 7'h7f;
	localparam logic [6:0] JTP_IR_CAPTURE = 7'h01;
	localparam logic [31:0] JTP_ID_UNIT_DEFAULT = 32'h0000_0001; // Arbitrary value
	localparam logic [31:0] JTP_ID_CORE_DEFAULT = 32'h0000_0003; // Arbitrary value
	localparam int JTP_POR_CYC = 4;
	localparam logic [2:0] JTP_POR_LAST = 3'h3;
	// Idle pin levels {tck, tms, tdi, trst_n}: clock low, the rest pulled high
	localparam logic [3:0] JTP_PIN_IDLE = 4'h7;

	typedef enum logic [3:0] {
		JTP_TLR, JTP_RTI, JTP_SEL_DR, JTP_CAP_DR, JTP_SH_DR, JTP_EX1_DR, JTP_PAU_DR,
		JTP_EX2_DR, JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR, JTP_SH_IR, JTP_EX1_IR,
		JTP_PAU_IR, JTP_EX2_IR, JTP_UPD_IR
	} jtp_state_e;

	// Synchronised test pins plus edge strobes of the test clock
	typedef struct packed {
		logic rise;
		logic fall;
		logic tms;
		logic tdi;
	} jtp_pins_s;

	// Test data output with its enable
	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} jtp_out_s;
endpackage : jtp_pkg

// >>> src/jtp_pin_sync.sv
// Two-stage synchronisers for the test pins and edge finder for the test clock.
// Assumes the system clock runs well above twice the test clock rate.
`timescale 1ns/1ps
`default_nettype none
module jtp_pin_sync (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic trst_n_i,
	output var jtp_pkg::jtp_pins_s pins_o,
	output logic trst_n_o
);
	import jtp_pkg::*;

	logic [3:0] meta_reg;
	logic [3:0] sync_reg;
	logic tck_last_reg;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			// Reset to idle levels, or a false clock edge follows reset
			meta_reg <= JTP_PIN_IDLE;
			sync_reg <= JTP_PIN_IDLE;
			tck_last_reg <= 1'b0;
		end else begin
			meta_reg <= {tck_i, tms_i, tdi_i, trst_n_i};
			sync_reg <= meta_reg;
			tck_last_reg <= sync_reg[3];
		end
	end

	assign pins_o.rise = sync_reg[3] & ~tck_last_reg;
	assign pins_o.fall = ~sync_reg[3] & tck_last_reg;
	assign pins_o.tms = sync_reg[2];
	assign pins_o.tdi = sync_reg[1];
	assign trst_n_o = sync_reg[0];
endmodule : jtp_pin_sync
`default_nettype wire

// >>> src/jtp_tap_top.sv
// Function
// - In reset state the active instruction becomes the ident opcode.
// - Five high tms samples from anywhere reach reset and stay there.
// - Low test reset forces the reset state without the test clock.
// - A glitch out of reset returns after three high tms samples.
// - From reset, low tms goes to idle, high stays.
// - Idle holds on low tms, high goes to select data scan.
// - Select data scan: low to capture data, high to select instruction scan.
// - Capture data loads selected register; low tms to shift, else exit one.
// - Shift data moves one bit toward output; high tms to exit one.
// - Exit one data: high to update, low to pause.
// - Pause data holds registers; high tms to exit two.
// - Exit two data: high to update, low back to shift.
// - Update data changes no register; high to select data, else idle.
// - Instruction changes only in instruction update or reset.
// - Select instruction scan: low to capture, high to reset.
// - Capture instruction loads 0000001; low to shift, else exit one.
// - Shift instruction moves one bit per rising edge; high to exit one.
// - Exit one instruction: high to update, low to pause.
// - Pause instruction holds; high tms to exit two.
// - Exit two instruction: high to update, low back to shift.
// - Update instruction latches on falling edge and becomes active.
// - Two controllers sit in series on the serial path.
// - Test data out changes after falling edge, driven only while shifting.
// - Instruction registers are seven bits with shift and latched stages.
// - Test reset leaves the latched instruction at the ident opcode.
// - Ident opcode 1111110 selects the 32-bit ident register.
// Top: pin synchroniser, power-on reset, two chained controllers.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_top #(
	parameter logic [31:0] ID_UNIT = jtp_pkg::JTP_ID_UNIT_DEFAULT,
	parameter logic [31:0] ID_CORE = jtp_pkg::JTP_ID_CORE_DEFAULT
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic trst_n_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic [6:0] unit_ir_o,
	output logic [6:0] core_ir_o,
	output logic unit_reset_o
);
	import jtp_pkg::*;

	jtp_pins_s pins;
	jtp_pins_s core_pins;
	jtp_out_s out_reg;
	jtp_state_e unit_state, core_state;
	logic trst_sync_n;
	logic [2:0] por_cnt_reg;
	logic por_done_reg;
	logic tap_rst_n;
	logic unit_sdo;
	logic core_sdo;
	logic shifting;

	jtp_pin_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.arst_n_i(arst_n_i),
		.tck_i(tck_i),
		.tms_i(tms_i),
		.tdi_i(tdi_i),
		.trst_n_i(trst_n_i),
		.pins_o(pins),
		.trst_n_o(trst_sync_n)
	);

	// Power-on stretch so both controllers begin in reset after power-up
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			por_cnt_reg <= 3'h0;
			por_done_reg <= 1'b0;
		end else if (!por_done_reg) begin
			por_cnt_reg <= por_cnt_reg + 3'h1;
			por_done_reg <= (por_cnt_reg == JTP_POR_LAST);
		end
	end

	// Test reset acts on controllers without waiting for the test clock
	assign tap_rst_n = arst_n_i & por_done_reg & trst_sync_n;

	jtp_tap_unit #(.ID_VALUE(ID_UNIT)) u_unit (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(tap_rst_n),
		.pins_i(pins),
		.sdo_o(unit_sdo),
		.state_o(unit_state),
		.ir_o(unit_ir_o)
	);

	// Core controller takes its serial input from the unit's output
	assign core_pins = '{rise: pins.rise, fall: pins.fall, tms: pins.tms, tdi: unit_sdo};

	jtp_tap_unit #(.ID_VALUE(ID_CORE)) u_core (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(tap_rst_n),
		.pins_i(core_pins),
		.sdo_o(core_sdo),
		.state_o(core_state),
		.ir_o(core_ir_o)
	);

	assign shifting = (unit_state == JTP_SH_DR) || (unit_state == JTP_SH_IR);

	// Output and enable both move on the falling test clock edge only
	always_ff @(posedge ref_clk_i or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			out_reg <= '{tdo: 1'b0, tdo_oe: 1'b0};
		end else if (pins.fall) begin
			out_reg <= '{tdo: core_sdo, tdo_oe: shifting};
		end
	end

	assign tdo_o = out_reg.tdo;
	assign tdo_oe_o = out_reg.tdo_oe;
	assign unit_reset_o = (unit_state == JTP_TLR);

	lockstep_a: assert property (@(posedge ref_clk_i) disable iff (!tap_rst_n)
		unit_state == core_state)
		else $error("chained controllers out of step");
	oe_shift_a: assert property (@(posedge ref_clk_i) disable iff (!tap_rst_n)
		tdo_oe_o |-> unit_state inside {JTP_SH_DR, JTP_SH_IR, JTP_EX1_DR, JTP_EX1_IR})
		else $error("output enabled outside shifting");
	tdo_fall_a: assert property (@(posedge ref_clk_i) disable iff (!tap_rst_n)
		!pins.fall |=> $stable(tdo_o))
		else $error("test data out changed without falling edge");
	reset_ir_a: assert property (@(posedge ref_clk_i) disable iff (!tap_rst_n)
		$rose(tap_rst_n) |-> unit_ir_o == JTP_OP_IDCODE && core_ir_o == JTP_OP_IDCODE)
		else $error("instruction not ident after reset");
	por_start_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		!por_done_reg |-> unit_state == JTP_TLR && core_state == JTP_TLR)
		else $error("controller left power-on reset early");
endmodule : jtp_tap_top
`default_nettype wire

// >>> tb/jtp_host_model.sv
// Tester model: drives test clock, mode select, data in and test reset.
// Assumes one task call at a time; the test clock stands still between calls.
`timescale 1ns/1ps
`default_nettype none
module jtp_host_model (
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	output logic trst_n_o,
	input wire logic tdo_i,
	input wire logic tdo_oe_i
);
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b1;
	end
	// One 125 ns period; data out is taken just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
		tck_o = 1'b0;
		tms_o = tms;
		tdi_o = tdi;
		#62.5;
		tdo = tdo_i;
		oe = tdo_oe_i;
		tck_o = 1'b1;
		#62.5;
	endtask : step
	// Parks the clock low so a system reset cannot fake a rising edge
	task automatic park();
		tck_o = 1'b0;
		#62.5;
	endtask : park
	task automatic test_reset();
		trst_n_o = 1'b0;
		#100;
		trst_n_o = 1'b1;
		#100;
	endtask : test_reset
endmodule : jtp_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Bench: a queue model of both chained controllers checked at every test clock.
// Assumes the host model paces the test clock and samples data out.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import jtp_pkg::*;
	localparam logic [31:0] ID_U = 32'h0000_00a5; // Arbitrary value
	localparam logic [31:0] ID_C = 32'h0000_005a; // Arbitrary value
	logic ref_clk, arst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, unit_reset, t_o, t_oe;
	logic [6:0] unit_ir, core_ir, m_uir, m_cir;
	logic [31:0] r;
	int n_fail = 0, checks = 0, cyc = 0;
	integer seed = 32'hea04;
	jtp_state_e st;
	logic sh_q[$];

	jtp_tap_top #(.ID_UNIT(ID_U), .ID_CORE(ID_C)) DUT (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
		.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
		.tdo_oe_o(tdo_oe), .unit_ir_o(unit_ir), .core_ir_o(core_ir), .unit_reset_o(unit_reset));
	jtp_host_model HOST (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
		.tdo_i(tdo), .tdo_oe_i(tdo_oe));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end

	function automatic jtp_state_e nx(jtp_state_e s, logic m);
		case (s)
			JTP_TLR: return m ? JTP_TLR : JTP_RTI;
			JTP_RTI: return m ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_DR: return m ? JTP_SEL_IR : JTP_CAP_DR;
			JTP_CAP_DR: return m ? JTP_EX1_DR : JTP_SH_DR;
			JTP_SH_DR: return m ? JTP_EX1_DR : JTP_SH_DR;
			JTP_EX1_DR: return m ? JTP_UPD_DR : JTP_PAU_DR;
			JTP_PAU_DR: return m ? JTP_EX2_DR : JTP_PAU_DR;
			JTP_EX2_DR: return m ? JTP_UPD_DR : JTP_SH_DR;
			JTP_UPD_DR, JTP_UPD_IR: return m ? JTP_SEL_DR : JTP_RTI;
			JTP_SEL_IR: return m ? JTP_TLR : JTP_CAP_IR;
			JTP_CAP_IR: return m ? JTP_EX1_IR : JTP_SH_IR;
			JTP_SH_IR: return m ? JTP_EX1_IR : JTP_SH_IR;
			JTP_EX1_IR: return m ? JTP_UPD_IR : JTP_PAU_IR;
			JTP_PAU_IR: return m ? JTP_EX2_IR : JTP_PAU_IR;
			default: return m ? JTP_UPD_IR : JTP_SH_IR;
		endcase
	endfunction : nx

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic load(logic [31:0] cv, int cw, logic [31:0] uv, int uw);
		sh_q.delete();
		for (int i = 0; i < cw; i++) sh_q.push_back(cv[i]);
		for (int i = 0; i < uw; i++) sh_q.push_back(uv[i]);
	endtask : load

	task automatic model_reset();
		st = JTP_TLR;
		m_uir = JTP_OP_IDCODE;
		m_cir = JTP_OP_IDCODE;
	endtask : model_reset

	// Tail of the chain (core side) reaches data out first
	task automatic bit_step(logic m, logic d);
		if (st == JTP_UPD_IR) begin
			for (int i = 0; i < 7; i++) m_cir[i] = sh_q[i];
			for (int i = 0; i < 7; i++) m_uir[i] = sh_q[i + 7];
		end
		if (st == JTP_TLR) model_reset();
		HOST.step(m, d, t_o, t_oe);
		chk("tdo_oe", st inside {JTP_SH_DR, JTP_SH_IR}, t_oe);
		if (t_oe === 1'b1) chk("tdo", sh_q[0], t_o);
		chk("unit_ir", m_uir, unit_ir);
		chk("core_ir", m_cir, core_ir);
		if (st inside {JTP_SH_DR, JTP_SH_IR}) begin
			void'(sh_q.pop_front());
			sh_q.push_back(d);
		end
		if (st == JTP_CAP_IR) load(JTP_IR_CAPTURE, 7, JTP_IR_CAPTURE, 7);
		if (st == JTP_CAP_DR) load(m_cir == JTP_OP_IDCODE ? ID_C : 32'h0,
			m_cir == JTP_OP_IDCODE ? 32 : 1, m_uir == JTP_OP_IDCODE ? ID_U : 32'h0,
			m_uir == JTP_OP_IDCODE ? 32 : 1);
		st = nx(st, m);
		chk("unit_reset", st == JTP_TLR, unit_reset);
	endtask : bit_step

	task automatic go(logic [7:0] pat, int n);
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			bit_step(pat[i], r[0]);
		end
	endtask : go

	task automatic scan(logic [32:0] v, int n);
		for (int i = 0; i < n; i++) bit_step(i == n - 1, v[i]);
	endtask : scan

	task automatic walk(int n);
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			bit_step(r[0], r[1]);
		end
	endtask : walk

	task automatic do_reset();
		HOST.park();
		@(negedge ref_clk);
		arst_n = 1'b0;
		repeat (16) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (8) @(negedge ref_clk);
		model_reset();
		chk("unit_ir", JTP_OP_IDCODE, unit_ir);
		chk("unit_reset", 1'b1, unit_reset);
		// Keeps every test pin change off the system clock edges
		#1.25;
	endtask : do_reset

	task automatic results();
		$display("Counts: %0d checks, %0d mismatches", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results

	initial begin
		arst_n = 1'b0;
		do_reset();
		go(8'h0e, 4);
		$display("Test glitch done");
		go(8'h06, 5);
		scan({7'h7e, 7'h7f}, 14);
		go(8'h01, 2);
		go(8'h01, 3);
		scan(33'({$random(seed), $random(seed)}), 33);
		go(8'h01, 2);
		go(8'h03, 4);
		scan({7'h7f, 7'h7e}, 14);
		go(8'h01, 2);
		go(8'h01, 3);
		scan(33'({$random(seed), $random(seed)}), 20);
		go(8'h04, 4);
		scan(33'({$random(seed), $random(seed)}), 13);
		go(8'h01, 2);
		$display("Test scans done");
		for (int k = 0; k < 4; k++) begin
			walk(100);
			go(8'h1f, 5);
		end
		$display("Test walk done");
		go(8'h06, 5);
		scan({7'h00, 7'h31}, 14);
		go(8'h01, 5);
		HOST.test_reset();
		model_reset();
		chk("unit_ir", JTP_OP_IDCODE, unit_ir);
		chk("core_ir", JTP_OP_IDCODE, core_ir);
		chk("unit_reset", 1'b1, unit_reset);
		walk(30);
		do_reset();
		walk(40);
		$display("Test resets done");
		results();
	end
endmodule : tb_top
`default_nettype wire
